// ### scl_ctrl_host.sv
// Controller end: buffers configuration words, shifts them out and strobes the latches.
//
// Operation
// - Device shifts data on rising serial clock.
// - Serial output shows last shift stage.
// - Switch 31 bit first, switch 0 last.
// - Strobe stays high while bits shift.
// - Strobe falling edge copies shift register to latches.
// - Latches hold while strobe stays high.
// - Clear high forces all latches off.
// - Clear never touches the shift register.
// - Serial clock never exceeds 66 MHz.
// - Update all switches by one strobe.
// - Serial output feeds next device input.
// - Chain needs N times 32 clocks.
// - One low strobe pulse after whole chain.
// - Returned serial data may be read back.
// - Clock, clear and strobe may be shared.
`timescale 1ns/1ps
module scl_ctrl_host
   import scl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   scl_link_if.host               link,
   input  wire scl_pkg::scl_word_t wordData,
   input  wire logic              wordValid,
   output logic                   wordReady,
   input  wire logic              clearSwitches,
   output logic                   busy,
   output scl_pkg::scl_word_t     readbackData,
   output logic                   readbackValid
);
   import scl_pkg::*;

   // Two-entry word buffer.
   scl_word_t         buf_r [2];
   logic              wrPtr_r;
   logic              rdPtr_r;
   logic [1:0]        count_r;
   logic [1:0]        count_nxt;
   logic              ready_r;
   logic              push;
   logic              pop;
   scl_word_t         head;

   // Shifter state.
   scl_state_t        state_r;
   logic [CNT_W-1:0]  timer_r;
   logic [BIT_W-1:0]  bitIdx_r;
   logic [WORD_W-1:0] wordIdx_r;
   scl_word_t         shift_r;
   scl_word_t         rbShift_r;
   scl_word_t         rbData_r;
   logic              rbValid_r;
   logic              sclk_r;
   logic              sdata_r;
   logic              strobeN_r;
   logic              clear_r;
   logic              busy_r;
   logic              retS1_r;
   logic              retS2_r;
   logic              timerDone;
   logic              lastBit;
   logic              lastWord;
   logic              canStart;

   assign push      = wordValid & ready_r;
   assign pop       = (state_r == ST_LOAD) && (count_r != 2'h0);
   assign head      = buf_r[rdPtr_r];
   assign timerDone = (timer_r == HALF_LAST);
   assign lastBit   = (bitIdx_r == BIT_LAST);
   assign lastWord  = (wordIdx_r == WORD_LAST);
   assign canStart  = (count_r != 2'h0) && !clearSwitches;

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + 2'h1;
      end else if (pop && !push) begin
         count_nxt = count_r - 2'h1;
      end
   end

   // Buffer storage and pointers; a stalled shifter lets the buffer fill.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_r <= 1'h0;
         rdPtr_r <= 1'h0;
         count_r <= 2'h0;
         ready_r <= 1'h0;
      end else begin
         if (push) begin
            buf_r[wrPtr_r] <= wordData;
            wrPtr_r        <= ~wrPtr_r;
         end
         if (pop) begin
            rdPtr_r <= ~rdPtr_r;
         end
         count_r <= count_nxt;
         ready_r <= (count_nxt != 2'h2);
      end
   end

   // Return bit from the last device passes two flip-flops.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         retS1_r <= 1'h0;
         retS2_r <= 1'h0;
      end else begin
         retS1_r <= link.serialOut;
         retS2_r <= retS1_r;
      end
   end

   // Frame sequencer.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         timer_r   <= '0;
         bitIdx_r  <= '0;
         wordIdx_r <= '0;
         shift_r   <= SHIFT_RST;
         sclk_r    <= 1'h0;
         sdata_r   <= 1'h0;
         strobeN_r <= STROBE_IDLE;
         busy_r    <= 1'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               sclk_r    <= 1'h0;
               strobeN_r <= STROBE_IDLE;
               wordIdx_r <= '0;
               if (canStart) begin
                  busy_r  <= 1'h1;
                  state_r <= ST_LOAD;
               end else begin
                  busy_r <= 1'h0;
               end
            end
            ST_LOAD: begin
               // Serial clock rests low while waiting for the next word.
               if (pop) begin
                  shift_r  <= head;
                  sdata_r  <= head[LAST_BIT];
                  bitIdx_r <= '0;
                  timer_r  <= '0;
                  state_r  <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (timerDone) begin
                  sclk_r  <= 1'h1;
                  timer_r <= '0;
                  state_r <= ST_HIGH;
               end else begin
                  timer_r <= timer_r + 4'h1;
               end
            end
            ST_HIGH: begin
               if (timerDone) begin
                  sclk_r  <= 1'h0;
                  timer_r <= '0;
                  shift_r <= {shift_r[LAST_BIT-1:0], 1'h0};
                  sdata_r <= shift_r[LAST_BIT-1];
                  if (!lastBit) begin
                     bitIdx_r <= bitIdx_r + 5'h01;
                     state_r  <= ST_LOW;
                  end else if (!lastWord) begin
                     wordIdx_r <= wordIdx_r + 4'h1;
                     state_r   <= ST_LOAD;
                  end else begin
                     state_r <= ST_SETTLE;
                  end
               end else begin
                  timer_r <= timer_r + 4'h1;
               end
            end
            ST_SETTLE: begin
               if (timerDone) begin
                  timer_r   <= '0;
                  strobeN_r <= 1'h0;
                  state_r   <= ST_STROBE;
               end else begin
                  timer_r <= timer_r + 4'h1;
               end
            end
            ST_STROBE: begin
               if (timer_r == STROBE_LAST) begin
                  timer_r   <= '0;
                  strobeN_r <= STROBE_IDLE;
                  state_r   <= ST_RECOVER;
               end else begin
                  timer_r <= timer_r + 4'h1;
               end
            end
            ST_RECOVER: begin
               if (timerDone) begin
                  timer_r <= '0;
                  busy_r  <= 1'h0;
                  state_r <= ST_IDLE;
               end else begin
                  timer_r <= timer_r + 4'h1;
               end
            end
            default: begin
               state_r   <= ST_IDLE;
               sclk_r    <= 1'h0;
               strobeN_r <= STROBE_IDLE;
               busy_r    <= 1'h0;
            end
         endcase
      end
   end

   // Clear only passes while no frame runs, so clear stays low during shifting.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clear_r <= 1'h0;
      end else begin
         clear_r <= (state_r == ST_IDLE) && clearSwitches && !canStart;
      end
   end

   // Capture returned bits at each rising serial clock; one word per 32 bits.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rbShift_r <= SHIFT_RST;
         rbData_r  <= SHIFT_RST;
         rbValid_r <= 1'h0;
      end else begin
         rbValid_r <= 1'h0;
         if (state_r == ST_LOW && timerDone) begin
            rbShift_r <= {rbShift_r[LAST_BIT-1:0], retS2_r};
         end
         if (state_r == ST_HIGH && timerDone && lastBit) begin
            rbData_r  <= rbShift_r;
            rbValid_r <= 1'h1;
         end
      end
   end

   assign link.serialClk    = sclk_r;
   assign link.serialData   = sdata_r;
   assign link.latchStrobeN = strobeN_r;
   assign link.latchClear   = clear_r;
   assign wordReady         = ready_r;
   assign busy              = busy_r;
   assign readbackData      = rbData_r;
   assign readbackValid     = rbValid_r;

endmodule // scl_ctrl_host

// ### scl_link_chk.sv
// Assertions on the serial link between the switch controller and the switch device.
`timescale 1ns/1ps
module scl_link_chk
   import scl_pkg::*;
(
   input wire logic      clk,
   input wire logic      rst_n,
   input wire logic      serialClk,
   input wire logic      serialData,
   input wire logic      serialOut,
   input wire logic      latchStrobeN,
   input wire logic      latchClear,
   input wire scl_word_t switchOn
);
   logic      prevClk_r;
   logic [5:0] riseCnt_r;
   scl_word_t shadow_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Shadow of the shift register, built from the bits seen at each serial clock rise.
   always_ff @(posedge clk) begin
      prevClk_r <= rst_n ? serialClk : 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shadow_r <= 32'h0000_0000;
      end else if (serialClk && !prevClk_r) begin
         shadow_r <= {shadow_r[30:0], serialData};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || !latchStrobeN) begin
         riseCnt_r <= 6'h00;
      end else if (serialClk && !prevClk_r) begin
         riseCnt_r <= riseCnt_r + 6'h01;
      end
   end

   property p_strobeIdle;
      $rose(serialClk) |-> latchStrobeN && !latchClear;
   endproperty
   a_strobeIdle: assert property (p_strobeIdle)
      else $error("serial clock rose while strobe low or clear high");

   property p_clkHigh;
      $rose(serialClk) |-> serialClk[*4] ##1 !serialClk;
   endproperty
   a_clkHigh: assert property (p_clkHigh)
      else $error("serial clock high phase not four cycles");

   property p_dataStable;
      serialClk && $past(serialClk) |-> $stable(serialData);
   endproperty
   a_dataStable: assert property (p_dataStable)
      else $error("serial data moved while serial clock high");

   property p_outChange;
      !$stable(serialOut) |-> $past(serialClk, 3) && !$past(serialClk, 4);
   endproperty
   a_outChange: assert property (p_outChange)
      else $error("serial output changed away from a clock rise");

   property p_bitCount;
      $fell(latchStrobeN) |-> riseCnt_r == 6'h20;
   endproperty
   a_bitCount: assert property (p_bitCount)
      else $error("strobe not preceded by exactly 32 clock rises");

   property p_strobePulse;
      $fell(latchStrobeN) |-> !latchStrobeN[*4] ##1 latchStrobeN;
   endproperty
   a_strobePulse: assert property (p_strobePulse)
      else $error("strobe pulse not four cycles low");

   property p_strobeLoad;
      $fell(latchStrobeN) && !latchClear |-> ##4 switchOn == shadow_r;
   endproperty
   a_strobeLoad: assert property (p_strobeLoad)
      else $error("latches differ from shifted word after strobe");

   property p_latchHold;
      !$stable(switchOn) |-> !$past(latchStrobeN, 3) || $past(latchClear, 2)
         || $past(latchClear, 3);
   endproperty
   a_latchHold: assert property (p_latchHold)
      else $error("latches changed without strobe or clear");

   property p_clearZero;
      latchClear[*4] |-> switchOn == 32'h0000_0000;
   endproperty
   a_clearZero: assert property (p_clearZero)
      else $error("latches not zero while clear held");
endmodule // scl_link_chk

// ### scl_link_if.sv
// Serial link between the switch controller and the switch device.
`timescale 1ns/1ps
interface scl_link_if;
   logic serialClk;
   logic serialData;
   logic serialOut;
   logic latchStrobeN;
   logic latchClear;

   modport dev (
      input  serialClk,
      input  serialData,
      input  latchStrobeN,
      input  latchClear,
      output serialOut
   );

   modport host (
      output serialClk,
      output serialData,
      output latchStrobeN,
      output latchClear,
      input  serialOut
   );
endinterface

// ### scl_pkg.sv
// Shared constants and types for the switch configuration serial link.
package scl_pkg;

   // Shift and latch geometry.
   localparam int STAGES    = 32;
   localparam int LAST_BIT  = 31;
   localparam int CHAIN_LEN = 1;
   localparam int BIT_W     = 5;
   localparam int WORD_W    = 4;

   // Clock and serial clock timing.
   localparam int CLK_PERIOD_NS      = 25;
   localparam int SCLK_MAX_MHZ       = 66;
   localparam int SCLK_MIN_PERIOD_NS = (1000 + SCLK_MAX_MHZ - 1) / SCLK_MAX_MHZ;
   localparam int SCLK_MIN_CYC_RAW   = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_MIN_CYC       = (SCLK_MIN_CYC_RAW < 1) ? 1 : SCLK_MIN_CYC_RAW;

   // Each serial clock phase must outlast the pin synchronisers at both ends.
   localparam int SYNC_STAGES = 2;
   localparam int HALF_CYC_RAW = 2 * SYNC_STAGES;
   localparam int HALF_CYC     = (HALF_CYC_RAW < SCLK_MIN_CYC) ? SCLK_MIN_CYC : HALF_CYC_RAW;
   localparam int STROBE_CYC   = 4;

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0]  HALF_LAST   = CNT_W'(HALF_CYC - 1);
   localparam logic [CNT_W-1:0]  STROBE_LAST = CNT_W'(STROBE_CYC - 1);
   localparam logic [BIT_W-1:0]  BIT_LAST    = BIT_W'(LAST_BIT);
   localparam logic [WORD_W-1:0] WORD_LAST   = WORD_W'(CHAIN_LEN - 1);

   // Reset values.
   localparam logic [STAGES-1:0] SHIFT_RST  = 32'h0000_0000;
   localparam logic [STAGES-1:0] LATCH_RST  = 32'h0000_0000;
   localparam logic              STROBE_IDLE = 1'h1;

   typedef logic [STAGES-1:0] scl_word_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_LOAD    = 3'h1,
      ST_LOW     = 3'h2,
      ST_HIGH    = 3'h3,
      ST_SETTLE  = 3'h4,
      ST_STROBE  = 3'h5,
      ST_RECOVER = 3'h6
   } scl_state_t;

endpackage

// ### scl_switch_dev.sv
// Switch device end: 32-stage shift register, output latches and clear.
`timescale 1ns/1ps
module scl_switch_dev
   import scl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   scl_link_if.dev                link,
   output scl_pkg::scl_word_t     switchOn
);
   import scl_pkg::*;

   logic      sclkS1_r, sclkS2_r, sclkD_r;
   logic      dataS1_r, dataS2_r;
   logic      strbS1_r, strbS2_r, strbD_r;
   logic      clrS1_r, clrS2_r;
   scl_word_t shift_r;
   scl_word_t latch_r;
   logic      shiftEdge;
   logic      strobeFall;

   // Pin synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclkS1_r <= 1'h0;
         sclkS2_r <= 1'h0;
         sclkD_r  <= 1'h0;
         dataS1_r <= 1'h0;
         dataS2_r <= 1'h0;
         strbS1_r <= STROBE_IDLE;
         strbS2_r <= STROBE_IDLE;
         strbD_r  <= STROBE_IDLE;
         clrS1_r  <= 1'h0;
         clrS2_r  <= 1'h0;
      end else begin
         sclkS1_r <= link.serialClk;
         sclkS2_r <= sclkS1_r;
         sclkD_r  <= sclkS2_r;
         dataS1_r <= link.serialData;
         dataS2_r <= dataS1_r;
         strbS1_r <= link.latchStrobeN;
         strbS2_r <= strbS1_r;
         strbD_r  <= strbS2_r;
         clrS1_r  <= link.latchClear;
         clrS2_r  <= clrS1_r;
      end
   end

   assign shiftEdge  = sclkS2_r & ~sclkD_r;
   assign strobeFall = ~strbS2_r & strbD_r;

   // Shift register ignores clear entirely.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shift_r <= SHIFT_RST;
      end else if (shiftEdge) begin
         shift_r <= {shift_r[LAST_BIT-1:0], dataS2_r};
      end
   end

   // Clear has priority over a strobe arriving in the same cycle.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latch_r <= LATCH_RST;
      end else if (clrS2_r) begin
         latch_r <= LATCH_RST;
      end else if (strobeFall) begin
         latch_r <= shift_r;
      end
   end

   assign link.serialOut = shift_r[LAST_BIT];
   assign switchOn       = latch_r;

endmodule // scl_switch_dev

// ### tb_top.sv
// Testbench joining the controller and device ends of the switch link.
`timescale 1ns/1ps
module tb_top;
   import scl_pkg::*;
   typedef struct packed {scl_word_t word; scl_word_t expRead;} scl_row_t;
   logic      clk, rst_n, wordValid, clearSwitches, sawFull;
   logic      wordReady, busy, readbackValid;
   scl_word_t wordData, switchOn, readbackData, rbData;
   int        nFail = 0;
   int        testsRun = 0;
   scl_row_t  rows [4] = '{'{32'h8000_0001, 32'h0000_0000}, '{32'hFFFF_FFFF, 32'h8000_0001},
                          '{32'h0000_0000, 32'hFFFF_FFFF}, '{32'hA5A5_5A5A, 32'h0000_0000}};

   scl_link_if link ();
   scl_ctrl_host i_scl_ctrl_host (.clk(clk), .rst_n(rst_n), .link(link.host),
      .wordData(wordData), .wordValid(wordValid), .wordReady(wordReady),
      .clearSwitches(clearSwitches), .busy(busy), .readbackData(readbackData),
      .readbackValid(readbackValid));
   scl_switch_dev i_scl_switch_dev (.clk(clk), .rst_n(rst_n), .link(link.dev),
      .switchOn(switchOn));
   scl_link_chk i_scl_link_chk (.clk(clk), .rst_n(rst_n), .serialClk(link.serialClk),
      .serialData(link.serialData), .serialOut(link.serialOut),
      .latchStrobeN(link.latchStrobeN), .latchClear(link.latchClear), .switchOn(switchOn));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (readbackValid === 1'b1) begin
         rbData <= readbackData;
      end
   end

   task automatic endOfTest;
      $display("checks %0d errors %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic checkWord(input string name, input scl_word_t exp, input scl_word_t got);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic checkBit(input string name, input logic exp, input logic got);
      testsRun++;
      if (got !== exp) begin
         nFail++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Called at a falling edge; returns at the falling edge after the word was taken.
   task automatic push(input scl_word_t w);
      int i;
      wordData = w;
      wordValid = 1'b1;
      for (i = 0; i < 2000 && wordReady !== 1'b1; i++) begin
         @(negedge clk);
         sawFull = 1'b1;
      end
      @(negedge clk);
   endtask

   // A frame counts as finished once busy has stayed low for twelve cycles.
   task automatic waitIdle;
      int i;
      int q;
      q = 0;
      for (i = 0; i < 3000 && q < 12; i++) begin
         @(negedge clk);
         q = (busy === 1'b0) ? q + 1 : 0;
      end
      checkBit("idle", 1'b0, busy);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      nFail++;
      endOfTest;
   end

   initial begin
      rst_n = 1'b0;
      wordValid = 1'b0;
      wordData = 32'h0000_0000;
      clearSwitches = 1'b0;
      sawFull = 1'b0;
      repeat (6) @(negedge clk);
      checkWord("switchOn", 32'h0000_0000, switchOn);
      checkBit("latchStrobeN", 1'b1, link.latchStrobeN);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      checkBit("wordReady", 1'b1, wordReady);
      foreach (rows[i]) begin
         push(rows[i].word);
         wordValid = 1'b0;
         waitIdle;
         checkWord("switchOn", rows[i].word, switchOn);
         checkWord("readback", rows[i].expRead, rbData);
      end
      push(32'h1234_5678);
      push(32'h0F0F_F0F0);
      push(32'hC3C3_3C3C);
      wordValid = 1'b0;
      waitIdle;
      checkBit("fullSeen", 1'b1, sawFull);
      checkWord("switchOn", 32'hC3C3_3C3C, switchOn);
      checkWord("readback", 32'h0F0F_F0F0, rbData);
      clearSwitches = 1'b1;
      push(32'h0000_FFFF);
      wordValid = 1'b0;
      repeat (20) @(negedge clk);
      checkBit("busy", 1'b0, busy);
      checkWord("switchOn", 32'h0000_0000, switchOn);
      clearSwitches = 1'b0;
      waitIdle;
      checkWord("switchOn", 32'h0000_FFFF, switchOn);
      checkWord("readback", 32'hC3C3_3C3C, rbData);
      // Reset in the middle of a frame must drop the link to idle and empty both ends.
      push(32'h5A5A_A5A5);
      wordValid = 1'b0;
      repeat (100) @(negedge clk);
      checkBit("busyMid", 1'b1, busy);
      rst_n = 1'b0;
      repeat (6) @(negedge clk);
      checkWord("switchOn", 32'h0000_0000, switchOn);
      checkBit("serialClk", 1'b0, link.serialClk);
      checkBit("latchStrobeN", 1'b1, link.latchStrobeN);
      checkBit("serialOut", 1'b0, link.serialOut);
      checkBit("busy", 1'b0, busy);
      rst_n = 1'b1;
      push(32'h00FF_FF00);
      wordValid = 1'b0;
      waitIdle;
      checkWord("switchOn", 32'h00FF_FF00, switchOn);
      checkWord("readback", 32'h0000_0000, rbData);
      endOfTest;
   end
endmodule // tb_top
